/* File: tmrc_pkg.sv */
// Constants shared by the timer output compare block
package tmrc_pkg;

    localparam int unsigned CHANNELS = 2;

    // Waveform mode codes
    localparam logic [3:0] WAVE_NORMAL      = 4'h0;
    localparam logic [3:0] WAVE_CTC_CMP     = 4'h4;
    localparam logic [3:0] WAVE_FAST_8      = 4'h5;
    localparam logic [3:0] WAVE_FAST_9      = 4'h6;
    localparam logic [3:0] WAVE_FAST_10     = 4'h7;
    localparam logic [3:0] WAVE_PFC_CAP     = 4'h8;
    localparam logic [3:0] WAVE_PFC_CMP     = 4'h9;
    localparam logic [3:0] WAVE_CTC_CAP     = 4'hC;
    localparam logic [3:0] WAVE_RESERVED    = 4'hD;
    localparam logic [3:0] WAVE_FAST_CAP    = 4'hE;
    localparam logic [3:0] WAVE_FAST_CMP    = 4'hF;

    // Output action codes
    localparam logic [1:0] ACT_NONE         = 2'h0;
    localparam logic [1:0] ACT_TOGGLE       = 2'h1;
    localparam logic [1:0] ACT_CLEAR        = 2'h2;
    localparam logic [1:0] ACT_SET          = 2'h3;

    // Fixed TOP masks applied to compare writes
    localparam logic [15:0] MASK_FAST_8     = 16'h00FF;
    localparam logic [15:0] MASK_FAST_9     = 16'h01FF;
    localparam logic [15:0] MASK_FAST_10    = 16'h03FF;
    localparam logic [15:0] MASK_FULL       = 16'hFFFF;

    // Register write targets on the CPU write port
    typedef enum logic [2:0] {
        WR_CMP_A_HIGH = 3'b000,
        WR_CMP_A_LOW  = 3'b001,
        WR_CMP_B_HIGH = 3'b010,
        WR_CMP_B_LOW  = 3'b011,
        WR_FLAG_CLR   = 3'b100,
        WR_FORCE      = 3'b101
    } tmrc_wr_t;

    // Bit positions of channels in flag and force writes
    localparam int unsigned BIT_CH_A        = 0;
    localparam int unsigned BIT_CH_B        = 1;

    // Reset values
    localparam logic [15:0] CMP_RST         = 16'h0000;
    localparam logic [7:0]  TEMP_RST        = 8'h00;
    localparam logic        OC_RST          = 1'b0;
    localparam logic        FLAG_RST        = 1'b0;

endpackage

/* File: tmrc_wave.sv */
// Output state next-value logic for one compare channel
`timescale 1ns/10ps
module tmrc_wave (
    input  wire logic       pwm_mode,
    input  wire logic       fast_mode,
    input  wire logic [1:0] action,
    input  wire logic       hit,
    input  wire logic       force_hit,
    input  wire logic       at_bottom,
    input  wire logic       count_down,
    input  wire logic       oc_now,
    output logic            oc_next
);

    always_comb
    begin
        oc_next = oc_now;
        if (!pwm_mode)
        begin
            if (hit || force_hit)
            begin
                unique case (action)
                    tmrc_pkg::ACT_NONE:   oc_next = oc_now;
                    tmrc_pkg::ACT_TOGGLE: oc_next = ~oc_now;
                    tmrc_pkg::ACT_CLEAR:  oc_next = 1'b0;
                    tmrc_pkg::ACT_SET:    oc_next = 1'b1;
                endcase
            end
        end
        else if (action[1])
        begin
            // PWM polarity from the low action bit
            if (fast_mode)
            begin
                if (hit)
                    oc_next = action[0];
                else if (at_bottom)
                    oc_next = ~action[0];
            end
            else if (hit)
            begin
                oc_next = count_down ? ~action[0] : action[0];
            end
        end
    end

endmodule

/* File: tmrc_compare.sv */
// Two-channel output compare unit of the 16-bit timer
`timescale 1ns/10ps
module tmrc_compare (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     timer_tick,
    input  wire logic [15:0]              counter_value,
    input  wire logic                     counter_at_top,
    input  wire logic                     counter_at_bottom,
    input  wire logic                     counter_down,
    input  wire logic                     counter_write,
    input  wire logic [3:0]               waveform_select,
    input  wire logic                     cpu_wr_en,
    input  wire tmrc_pkg::tmrc_wr_t       cpu_wr_target,
    input  wire logic [7:0]               cpu_wr_data,
    input  wire logic [1:0]               irq_ack,
    input  wire logic [1:0]               compare_irq_enable,
    input  wire logic [3:0]               output_action_select,
    input  wire logic [1:0]               port_value,
    input  wire logic [1:0]               output_pin_direction,
    output logic [15:0]                   compare_value_a,
    output logic [15:0]                   compare_value_b,
    output logic [15:0]                   top_value_a,
    output logic                          top_match_a,
    output logic [1:0]                    compare_match_flag,
    output logic [1:0]                    irq_request,
    output logic [1:0]                    compare_output,
    output logic [1:0]                    pin_out,
    output logic [1:0]                    pin_oe_n
);

    typedef struct packed {
        logic [7:0]       temp;
        logic [1:0][15:0] buf_v;
        logic [1:0][15:0] act;
        logic [1:0]       flag;
        logic [1:0]       oc;
        logic             block;
        logic             top_hit;
        logic [1:0]       irq;
        logic [1:0]       pin;
        logic [1:0]       oe_n;
    } tmrc_state_t;

    tmrc_state_t st_r;
    tmrc_state_t st_nxt;

    logic        pwm_mode;
    logic        fast_mode;
    logic        bot_update;
    logic [15:0] wr_mask;
    logic [1:0]  hit;
    logic [1:0]  force_hit;
    logic [1:0]  oc_next;

    // Mode classification from waveform bits only
    always_comb
    begin
        pwm_mode  = !(waveform_select == tmrc_pkg::WAVE_NORMAL  ||
                      waveform_select == tmrc_pkg::WAVE_CTC_CMP ||
                      waveform_select == tmrc_pkg::WAVE_CTC_CAP ||
                      waveform_select == tmrc_pkg::WAVE_RESERVED);
        fast_mode = waveform_select == tmrc_pkg::WAVE_FAST_8   ||
                    waveform_select == tmrc_pkg::WAVE_FAST_9   ||
                    waveform_select == tmrc_pkg::WAVE_FAST_10  ||
                    waveform_select == tmrc_pkg::WAVE_FAST_CAP ||
                    waveform_select == tmrc_pkg::WAVE_FAST_CMP;
        bot_update = waveform_select == tmrc_pkg::WAVE_PFC_CAP ||
                     waveform_select == tmrc_pkg::WAVE_PFC_CMP;
        unique case (waveform_select)
            tmrc_pkg::WAVE_FAST_8:  wr_mask = tmrc_pkg::MASK_FAST_8;
            tmrc_pkg::WAVE_FAST_9:  wr_mask = tmrc_pkg::MASK_FAST_9;
            tmrc_pkg::WAVE_FAST_10: wr_mask = tmrc_pkg::MASK_FAST_10;
            default:                wr_mask = tmrc_pkg::MASK_FULL;
        endcase
    end

    // Per-channel comparator, force decode and output state logic
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_ch
            // Match counted on a timer tick unless a counter write blocks it
            assign hit[ch] = timer_tick && !st_r.block &&
                             (counter_value == st_r.act[ch]);
            assign force_hit[ch] = cpu_wr_en && !pwm_mode &&
                                   cpu_wr_target == tmrc_pkg::WR_FORCE &&
                                   cpu_wr_data[ch];

            tmrc_wave u_wave (
                .pwm_mode   (pwm_mode),
                .fast_mode  (fast_mode),
                .action     (output_action_select[2*ch +: 2]),
                .hit        (hit[ch]),
                .force_hit  (force_hit[ch]),
                .at_bottom  (timer_tick && counter_at_bottom),
                .count_down (counter_down),
                .oc_now     (st_r.oc[ch]),
                .oc_next    (oc_next[ch])
            );
        end
    endgenerate

    always_comb
    begin
        logic        is_low;
        logic        is_high;
        logic        chan;
        logic [15:0] wr_val;
        logic        update;
        is_low  = 1'b0;
        is_high = 1'b0;
        chan    = 1'b0;
        wr_val  = 16'h0000;
        update  = 1'b0;
        st_nxt  = st_r;

        // Counter write blocks matches of the following timer tick
        if (counter_write)
            st_nxt.block = 1'b1;
        else if (timer_tick)
            st_nxt.block = 1'b0;

        // Double buffer transfer at TOP or BOTTOM in PWM modes
        update = pwm_mode && timer_tick &&
                 (bot_update ? counter_at_bottom : counter_at_top);
        if (update)
            st_nxt.act = st_r.buf_v;

        // Compare byte writes through the shared temp register
        if (cpu_wr_en)
        begin
            is_high = cpu_wr_target == tmrc_pkg::WR_CMP_A_HIGH ||
                      cpu_wr_target == tmrc_pkg::WR_CMP_B_HIGH;
            is_low  = cpu_wr_target == tmrc_pkg::WR_CMP_A_LOW ||
                      cpu_wr_target == tmrc_pkg::WR_CMP_B_LOW;
            chan    = cpu_wr_target == tmrc_pkg::WR_CMP_B_LOW;
        end
        if (is_high)
            st_nxt.temp = cpu_wr_data;
        if (is_low)
        begin
            wr_val = {st_r.temp, cpu_wr_data} & wr_mask;
            st_nxt.buf_v[chan] = wr_val;
            if (!pwm_mode)
                st_nxt.act[chan] = wr_val;
        end

        for (int i = 0; i < 2; i++)
        begin
            // Clears first so that a same-cycle match wins
            if (irq_ack[i] && st_r.irq[i])
                st_nxt.flag[i] = 1'b0;
            if (cpu_wr_en && cpu_wr_target == tmrc_pkg::WR_FLAG_CLR &&
                cpu_wr_data[i])
                st_nxt.flag[i] = 1'b0;
            if (hit[i])
                st_nxt.flag[i] = 1'b1;
            st_nxt.irq[i] = st_nxt.flag[i] && compare_irq_enable[i];
            st_nxt.oc[i] = oc_next[i];
            // Port override when any action bit is set
            st_nxt.pin[i] = (output_action_select[2*i +: 2] != 2'h0) ?
                            oc_next[i] : port_value[i];
            st_nxt.oe_n[i] = !output_pin_direction[i];
        end

        st_nxt.top_hit = hit[tmrc_pkg::BIT_CH_A];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r.temp    <= tmrc_pkg::TEMP_RST;
            st_r.buf_v   <= {2{tmrc_pkg::CMP_RST}};
            st_r.act     <= {2{tmrc_pkg::CMP_RST}};
            st_r.flag    <= {2{tmrc_pkg::FLAG_RST}};
            st_r.oc      <= {2{tmrc_pkg::OC_RST}};
            st_r.block   <= 1'b0;
            st_r.top_hit <= 1'b0;
            st_r.irq     <= 2'h0;
            st_r.pin     <= 2'h0;
            st_r.oe_n    <= 2'h3;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Reads return both bytes straight from the CPU-visible register
    assign compare_value_a    = st_r.buf_v[tmrc_pkg::BIT_CH_A];
    assign compare_value_b    = st_r.buf_v[tmrc_pkg::BIT_CH_B];
    assign top_value_a        = st_r.act[tmrc_pkg::BIT_CH_A];
    assign top_match_a        = st_r.top_hit;
    assign compare_match_flag = st_r.flag;
    assign irq_request        = st_r.irq;
    assign compare_output     = st_r.oc;
    assign pin_out            = st_r.pin;
    assign pin_oe_n           = st_r.oe_n;

endmodule

/* File: tmrc_cpu_model.sv */
// CPU write side model for the output compare block
`timescale 1ns/10ps
module tmrc_cpu_model (
    input  wire logic          clk,
    output logic               cpu_wr_en,
    output tmrc_pkg::tmrc_wr_t cpu_wr_target,
    output logic [7:0]         cpu_wr_data
);
    initial
    begin
        cpu_wr_en = 1'b0;
        cpu_wr_target = tmrc_pkg::WR_FLAG_CLR;
        cpu_wr_data = 8'h00;
    end
    // Single byte write, data inverted once released
    task automatic wr(input tmrc_pkg::tmrc_wr_t t, input logic [7:0] d);
        @(posedge clk);
        cpu_wr_en <= 1'b1;
        cpu_wr_target <= t;
        cpu_wr_data <= d;
        @(posedge clk);
        cpu_wr_en <= 1'b0;
        cpu_wr_data <= ~d;
    endtask
    // High byte then low byte on consecutive cycles
    task automatic wr16(input tmrc_pkg::tmrc_wr_t hi, input logic [15:0] v);
        @(posedge clk);
        cpu_wr_en <= 1'b1;
        cpu_wr_target <= hi;
        cpu_wr_data <= v[15:8];
        @(posedge clk);
        cpu_wr_target <= tmrc_pkg::tmrc_wr_t'(hi + 3'h1);
        cpu_wr_data <= v[7:0];
        @(posedge clk);
        cpu_wr_en <= 1'b0;
        cpu_wr_data <= ~v[7:0];
    endtask
endmodule

/* File: tmrc_compare_asserts.sv */
// Port assertions for the output compare block
`timescale 1ns/10ps
module tmrc_compare_asserts (
    input wire logic               clk,
    input wire logic               rst_n,
    input wire logic               timer_tick,
    input wire logic [15:0]        counter_value,
    input wire logic               counter_at_top,
    input wire logic               counter_write,
    input wire logic [3:0]         waveform_select,
    input wire logic               cpu_wr_en,
    input wire tmrc_pkg::tmrc_wr_t cpu_wr_target,
    input wire logic [7:0]         cpu_wr_data,
    input wire logic [3:0]         output_action_select,
    input wire logic [1:0]         output_pin_direction,
    input wire logic [15:0]        compare_value_b,
    input wire logic [15:0]        top_value_a,
    input wire logic               top_match_a,
    input wire logic [1:0]         compare_match_flag,
    input wire logic [1:0]         compare_output,
    input wire logic [1:0]         pin_oe_n
);
    logic blk_r;
    wire  hit_a = timer_tick && !blk_r && !counter_write
                  && counter_value == top_value_a;
    // Block window after a counter write
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) blk_r <= 1'b0;
        else if (counter_write) blk_r <= 1'b1;
        else if (timer_tick) blk_r <= 1'b0;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_flag_set; hit_a |=> compare_match_flag[0]; endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("flag A not set after match");
    property p_block; timer_tick && blk_r |=> !top_match_a; endproperty
    a_block: assert property (p_block)
        else $error("match seen right after counter write");
    property p_clr; cpu_wr_en && cpu_wr_target == tmrc_pkg::WR_FLAG_CLR
        && cpu_wr_data[0] && !timer_tick |=> !compare_match_flag[0];
    endproperty
    a_clr: assert property (p_clr)
        else $error("flag A not cleared by write");
    property p_act0; output_action_select[1:0] == 2'h0
        |=> $stable(compare_output[0]); endproperty
    a_act0: assert property (p_act0)
        else $error("output A changed with no action");
    property p_toggle; waveform_select == 4'h4 && hit_a
        && output_action_select[1:0] == 2'h1
        |=> compare_output[0] != $past(compare_output[0]); endproperty
    a_toggle: assert property (p_toggle)
        else $error("output A did not toggle");
    property p_oe; rst_n |=> pin_oe_n[0] == !$past(output_pin_direction[0]);
    endproperty
    a_oe: assert property (p_oe)
        else $error("pin A enable not from direction");
    property p_wr; cpu_wr_en && cpu_wr_target == tmrc_pkg::WR_CMP_B_HIGH
        ##1 cpu_wr_en && cpu_wr_target == tmrc_pkg::WR_CMP_B_LOW
        && waveform_select == 4'h0
        |=> compare_value_b == {$past(cpu_wr_data, 2), $past(cpu_wr_data)};
    endproperty
    a_wr: assert property (p_wr)
        else $error("compare B not loaded from both bytes");
    property p_buf; waveform_select == 4'hF && !(timer_tick && counter_at_top)
        |=> $stable(top_value_a); endproperty
    a_buf: assert property (p_buf)
        else $error("active compare A changed away from TOP");
endmodule
bind tmrc_compare tmrc_compare_asserts i_tmrc_compare_asserts (.clk, .rst_n,
    .timer_tick, .counter_value, .counter_at_top, .counter_write,
    .waveform_select, .cpu_wr_en, .cpu_wr_target, .cpu_wr_data,
    .output_action_select, .output_pin_direction, .compare_value_b,
    .top_value_a, .top_match_a, .compare_match_flag, .compare_output,
    .pin_oe_n);

/* File: test_tmrc_compare.sv */
// Testbench for the two-channel output compare block
`timescale 1ns/10ps
module test_tmrc_compare;
    logic        clk, rst_n, timer_tick, counter_at_top, counter_write;
    logic        counter_at_bottom, counter_down, top_match_a, cpu_wr_en;
    logic [1:0]  irq_ack, compare_irq_enable, port_value, pin_out, pin_oe_n;
    logic [1:0]  output_pin_direction, compare_match_flag, irq_request;
    logic [1:0]  compare_output, acts [5];
    logic [3:0]  waveform_select, output_action_select;
    logic [4:0]  exp_oc;
    logic [7:0]  cpu_wr_data;
    logic [15:0] counter_value, compare_value_a, compare_value_b, top_value_a;
    tmrc_pkg::tmrc_wr_t cpu_wr_target;
    int          errors, n_checks;
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    tmrc_compare i_tmrc_compare (.clk, .rst_n, .timer_tick, .counter_value,
        .counter_at_top, .counter_at_bottom, .counter_down, .counter_write,
        .waveform_select, .cpu_wr_en, .cpu_wr_target, .cpu_wr_data, .irq_ack,
        .compare_irq_enable, .output_action_select, .port_value,
        .output_pin_direction, .compare_value_a, .compare_value_b,
        .top_value_a, .top_match_a, .compare_match_flag, .irq_request,
        .compare_output, .pin_out, .pin_oe_n);
    tmrc_cpu_model i_tmrc_cpu_model (.clk, .cpu_wr_en, .cpu_wr_target,
        .cpu_wr_data);
    task automatic chk(input string n, input logic [15:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            errors++;
            $display("Error %s expected %h got %h", n, e, g);
        end
    endtask
    // One timer tick with the given counter value
    task automatic tk(input logic [15:0] v);
        @(posedge clk);
        counter_value <= v;
        timer_tick <= 1'b1;
        @(posedge clk);
        timer_tick <= 1'b0;
        #1;
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        {rst_n, timer_tick, counter_at_top, counter_write} = 4'h0;
        {counter_at_bottom, counter_down} = 2'h0;
        {irq_ack, compare_irq_enable, port_value, output_pin_direction} = 8'h14;
        {waveform_select, output_action_select} = 8'h00;
        counter_value = 16'h0000;
        acts = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h1};
        exp_oc = 5'b01101;
        repeat (2) @(posedge clk);
        #1;
        chk("oc reset", 16'h0000, compare_output);
        chk("oe reset", 16'h0003, pin_oe_n);
        @(posedge clk);
        rst_n <= 1'b1;
        $display("reset test done");
        i_tmrc_cpu_model.wr16(tmrc_pkg::WR_CMP_A_HIGH, 16'h1234);
        i_tmrc_cpu_model.wr16(tmrc_pkg::WR_CMP_B_HIGH, 16'h00A5);
        i_tmrc_cpu_model.wr(tmrc_pkg::WR_CMP_A_HIGH, 8'hFF);
        #1;
        chk("cmp a", 16'h1234, compare_value_a);
        chk("top a", 16'h1234, top_value_a);
        chk("cmp b", 16'h00A5, compare_value_b);
        $display("write test done");
        tk(16'h1234);
        chk("flag", 16'h0001, compare_match_flag);
        chk("irq", 16'h0001, irq_request);
        chk("pin", 16'h0001, pin_out);
        chk("top match", 16'h0001, top_match_a);
        @(posedge clk);
        irq_ack <= 2'h1;
        @(posedge clk);
        irq_ack <= 2'h0;
        #1;
        chk("flag ack", 16'h0000, compare_match_flag);
        tk(16'h00A5);
        chk("flag b", 16'h0002, compare_match_flag);
        chk("irq b", 16'h0000, irq_request);
        i_tmrc_cpu_model.wr(tmrc_pkg::WR_FLAG_CLR, 8'h02);
        #1;
        chk("flag clr", 16'h0000, compare_match_flag);
        @(posedge clk);
        counter_write <= 1'b1;
        @(posedge clk);
        counter_write <= 1'b0;
        tk(16'h1234);
        chk("flag blk", 16'h0000, compare_match_flag);
        $display("match test done");
        waveform_select <= 4'h4;
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk);
            output_action_select <= {2'h0, acts[i]};
            if (i < 2)
                i_tmrc_cpu_model.wr(tmrc_pkg::WR_FORCE, 8'h01);
            else
                tk(16'h1234);
            #1;
            if (i == 1)
                chk("flag frc", 16'h0000, compare_match_flag);
            chk("oc act", exp_oc[i], compare_output[0]);
        end
        output_pin_direction <= 2'h1;
        @(posedge clk);
        #1;
        chk("pin act", 16'h0000, pin_out);
        chk("oe act", 16'h0002, pin_oe_n);
        i_tmrc_cpu_model.wr(tmrc_pkg::WR_FLAG_CLR, 8'h01);
        #1;
        chk("flag clr a", 16'h0000, compare_match_flag);
        $display("action test done");
        output_action_select <= 4'h3;
        i_tmrc_cpu_model.wr(tmrc_pkg::WR_FORCE, 8'h01);
        waveform_select <= 4'hF;
        output_action_select <= 4'h2;
        i_tmrc_cpu_model.wr(tmrc_pkg::WR_FORCE, 8'h01);
        #1;
        chk("oc mode", 16'h0001, compare_output);
        i_tmrc_cpu_model.wr16(tmrc_pkg::WR_CMP_A_HIGH, 16'h0300);
        #1;
        chk("buf a", 16'h0300, compare_value_a);
        chk("act a", 16'h1234, top_value_a);
        counter_at_top <= 1'b1;
        tk(16'h0200);
        counter_at_top <= 1'b0;
        chk("act top", 16'h0300, top_value_a);
        tk(16'h0300);
        chk("pwm match", 16'h0000, compare_output);
        counter_at_bottom <= 1'b1;
        tk(16'h0000);
        counter_at_bottom <= 1'b0;
        chk("pwm bottom", 16'h0001, compare_output);
        waveform_select <= 4'h5;
        i_tmrc_cpu_model.wr16(tmrc_pkg::WR_CMP_A_HIGH, 16'h1234);
        #1;
        chk("mask a", 16'h0034, compare_value_a);
        $display("buffer test done");
        stop_test();
    end
    // Hang guard
    initial
    begin
        #20000;
        errors++;
        stop_test();
    end
endmodule
